// File: hdl/oac_amp_decode.sv
`timescale 1ns/1ps
`include "oac_consts.svh"

module oac_amp_decode
   import oac_pkg::*;
(
   input  wire logic [7:0] input_cfg,
   input  wire logic [7:0] function_cfg,
   input  wire logic [1:0] force_sel,
   output oac_amp_s        eff
);

   logic [2:0] func_raw;
   logic       force_any;

   always_comb
   begin
      func_raw  = function_cfg[`OAC_FUNC_HI:`OAC_FUNC_LO];
      force_any = (force_sel == `OAC_FORCE_CH0) || (force_sel == `OAC_FORCE_CH1);

      eff.inv_input_sel     = input_cfg[`OAC_INV_HI:`OAC_INV_LO];
      eff.noninv_input_sel  = input_cfg[`OAC_NONINV_HI:`OAC_NONINV_LO];
      eff.slew_power_sel    = input_cfg[`OAC_SLEW_HI:`OAC_SLEW_LO];
      eff.feedback_tap_sel  = function_cfg[`OAC_TAP_HI:`OAC_TAP_LO];
      eff.amp_function_sel  = oac_func_e'(func_raw);
      eff.input_range_limit = function_cfg[`OAC_RANGE_BIT];
      eff.forced            = force_any;

      // Switch force overrides inverting input and function
      if (force_sel == `OAC_FORCE_CH0)
      begin
         eff.inv_input_sel    = `OAC_FORCED_INV_CH0;
         eff.amp_function_sel = OAC_FN_INV_PGA;
      end
      else if (force_sel == `OAC_FORCE_CH1)
      begin
         eff.inv_input_sel    = `OAC_FORCED_INV_CH1;
         eff.amp_function_sel = OAC_FN_INV_PGA;
      end

      eff.amp_powered = (eff.slew_power_sel != 2'h0);
      eff.external_conv_route = input_cfg[`OAC_EXT_ROUTE_BIT]
                                && (eff.amp_function_sel != OAC_FN_GENERAL);
      eff.internal_conv_route = input_cfg[`OAC_INT_ROUTE_BIT] && eff.amp_powered;
   end

endmodule

// File: hdl/oac_consts.svh
`ifndef OAC_CONSTS_SVH
`define OAC_CONSTS_SVH

// Register indexes; byte address is four times the index
`define OAC_IDX_W           10
`define OAC_IDX_AMP0_INPUT  10'h0C0
`define OAC_IDX_AMP0_FUNC   10'h0C1
`define OAC_IDX_AMP1_INPUT  10'h0C2
`define OAC_IDX_AMP1_FUNC   10'h0C3
`define OAC_IDX_AMP2_INPUT  10'h0C4
`define OAC_IDX_AMP2_FUNC   10'h0C5
`define OAC_IDX_SWITCH      10'h0CF
`define OAC_IDX_STRIDE      10'h002

// Bus geometry
`define OAC_ADDR_W          12
`define OAC_DATA_W          32
`define OAC_NUM_AMPS        3
`define OAC_NUM_AMPS_SMALL  2

// Reset values
`define OAC_CTL_RESET       8'h00
`define OAC_SWC_RESET       8'h00

// Input configuration fields
`define OAC_INV_HI          7
`define OAC_INV_LO          6
`define OAC_NONINV_HI       5
`define OAC_NONINV_LO       4
`define OAC_SLEW_HI         3
`define OAC_SLEW_LO         2
`define OAC_EXT_ROUTE_BIT   1
`define OAC_INT_ROUTE_BIT   0

// Function configuration fields
`define OAC_TAP_HI          7
`define OAC_TAP_LO          5
`define OAC_FUNC_HI         4
`define OAC_FUNC_LO         2
`define OAC_RANGE_BIT       0
`define OAC_FUNC_WMASK      8'hFD

// Switch control force fields
`define OAC_FORCE0_LO       0
`define OAC_FORCE1_LO       4
`define OAC_FORCE_CH0       2'h1
`define OAC_FORCE_CH1       2'h2
`define OAC_FORCED_INV_CH0  2'h0
`define OAC_FORCED_INV_CH1  2'h1

`endif

// File: hdl/oac_pkg.sv
package oac_pkg;

   typedef enum logic [2:0]
   {
      OAC_FN_GENERAL    = 3'h0,
      OAC_FN_UNITY      = 3'h1,
      OAC_FN_RSVD2      = 3'h2,
      OAC_FN_COMPARE    = 3'h3,
      OAC_FN_NONINV_PGA = 3'h4,
      OAC_FN_RSVD5      = 3'h5,
      OAC_FN_INV_PGA    = 3'h6,
      OAC_FN_RSVD7      = 3'h7
   } oac_func_e;

   typedef struct packed
   {
      logic [1:0] inv_input_sel;
      logic [1:0] noninv_input_sel;
      logic [1:0] slew_power_sel;
      logic       external_conv_route;
      logic       internal_conv_route;
      logic [2:0] feedback_tap_sel;
      oac_func_e  amp_function_sel;
      logic       input_range_limit;
      logic       amp_powered;
      logic       forced;
   } oac_amp_s;

   typedef struct packed
   {
      logic       shunt1;
      logic       sw1_to_vss;
      logic [1:0] force1;
      logic       shunt0;
      logic       sw0_to_vss;
      logic [1:0] force0;
   } oac_switch_s;

endpackage

// File: hdl/oac_regs.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "oac_consts.svh"

module oac_regs
   import oac_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0
)
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`OAC_ADDR_W-1:0]    paddr,
   input  wire logic [`OAC_DATA_W-1:0]    pwdata,
   input  wire logic [3:0]                pstrb,
   output      logic [`OAC_DATA_W-1:0]    prdata,
   output      logic                      pready,
   output      logic                      pslverr,
   output      oac_amp_s [`OAC_NUM_AMPS-1:0] amp_cfg,
   output      oac_switch_s               switch_cfg
);

   localparam int NUM_MAPPED = SMALL_VARIANT ? `OAC_NUM_AMPS_SMALL : `OAC_NUM_AMPS;

   logic [7:0]               input_cfg_r  [`OAC_NUM_AMPS];
   logic [7:0]               func_cfg_r   [`OAC_NUM_AMPS];
   logic [7:0]               switch_r;
   logic                     pready_r;
   logic                     pslverr_r;
   logic [`OAC_DATA_W-1:0]   prdata_r;
   oac_amp_s [`OAC_NUM_AMPS-1:0] amp_cfg_r;
   oac_switch_s              switch_cfg_r;

   logic [`OAC_IDX_W-1:0]    idx;
   logic                     aligned;
   logic                     access;
   logic                     commit;
   logic                     wr_commit;
   logic                     byte_wr;
   logic                     hit_switch;
   logic [`OAC_NUM_AMPS-1:0] hit_input;
   logic [`OAC_NUM_AMPS-1:0] hit_func;
   logic                     hit_any;
   logic [7:0]               rd_byte;
   oac_amp_s [`OAC_NUM_AMPS-1:0] amp_eff;

   // Address decode
   always_comb
   begin
      idx        = paddr[`OAC_ADDR_W-1:2];
      aligned    = (paddr[1:0] == 2'h0);
      access     = psel && penable;
      commit     = access && pready_r;
      wr_commit  = commit && pwrite;
      byte_wr    = pstrb[0];
      hit_switch = SMALL_VARIANT && aligned && (idx == `OAC_IDX_SWITCH);
   end

   genvar gi;
   generate
      for (gi = 0; gi < `OAC_NUM_AMPS; gi = gi + 1)
      begin : g_amp
         localparam logic [`OAC_IDX_W-1:0] IDX_IN =
            `OAC_IDX_AMP0_INPUT + `OAC_IDX_STRIDE * `OAC_IDX_W'(gi);
         localparam logic [`OAC_IDX_W-1:0] IDX_FN = IDX_IN + `OAC_IDX_W'(1);
         localparam bit MAPPED = (gi < NUM_MAPPED);
         logic [1:0] force_sel;

         assign hit_input[gi] = MAPPED && aligned && (idx == IDX_IN);
         assign hit_func[gi]  = MAPPED && aligned && (idx == IDX_FN);

         // Only the small variant has force fields, for amps 0 and 1
         always_comb
         begin
            force_sel = 2'h0;
            if (SMALL_VARIANT && gi == 0)
            begin
               force_sel = switch_r[`OAC_FORCE0_LO +: 2];
            end
            else if (SMALL_VARIANT && gi == 1)
            begin
               force_sel = switch_r[`OAC_FORCE1_LO +: 2];
            end
         end

         // Input configuration register
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               input_cfg_r[gi] <= `OAC_CTL_RESET;
            end
            else if (wr_commit && byte_wr && hit_input[gi])
            begin
               input_cfg_r[gi] <= pwdata[7:0];
            end
         end

         // Function configuration register, reserved bit kept zero
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               func_cfg_r[gi] <= `OAC_CTL_RESET;
            end
            else if (wr_commit && byte_wr && hit_func[gi])
            begin
               func_cfg_r[gi] <= pwdata[7:0] & `OAC_FUNC_WMASK;
            end
         end

         oac_amp_decode u_decode
         (
            .input_cfg    (input_cfg_r[gi]),
            .function_cfg (func_cfg_r[gi]),
            .force_sel    (force_sel),
            .eff          (amp_eff[gi])
         );

         // Effective settings to the analog side
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               amp_cfg_r[gi] <= '0;
            end
            else
            begin
               amp_cfg_r[gi] <= amp_eff[gi];
            end
         end
      end
   endgenerate

   assign hit_any = (|hit_input) || (|hit_func) || hit_switch;

   // Switch control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         switch_r <= `OAC_SWC_RESET;
      end
      else if (wr_commit && byte_wr && hit_switch)
      begin
         switch_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         switch_cfg_r <= '0;
      end
      else
      begin
         switch_cfg_r <= oac_switch_s'(switch_r);
      end
   end

   // Read mux
   always_comb
   begin
      rd_byte = 8'h00;
      for (int i = 0; i < `OAC_NUM_AMPS; i++)
      begin
         if (hit_input[i])
         begin
            rd_byte = input_cfg_r[i];
         end
         if (hit_func[i])
         begin
            rd_byte = func_cfg_r[i];
         end
      end
      if (hit_switch)
      begin
         rd_byte = switch_r;
      end
   end

   // One wait state: ready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
      end
      else
      begin
         pready_r <= access && !pready_r;
      end
   end

   // Error on unmapped or unaligned address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pslverr_r <= 1'b0;
      end
      else
      begin
         pslverr_r <= access && !pready_r && !hit_any;
      end
   end

   // Read data captured with ready, zero otherwise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= '0;
      end
      else if (access && !pready_r && !pwrite)
      begin
         prdata_r <= {24'h000000, rd_byte};
      end
      else
      begin
         prdata_r <= '0;
      end
   end

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign amp_cfg    = amp_cfg_r;
   assign switch_cfg = switch_cfg_r;

endmodule

// File: sim/oac_regs_monitor.sv
`timescale 1ns/1ps
`include "oac_consts.svh"
module oac_regs_monitor
   import oac_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0
)
(
   input wire logic                         pclk,
   input wire logic                         presetn,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [`OAC_ADDR_W-1:0]       paddr,
   input wire logic [`OAC_DATA_W-1:0]       pwdata,
   input wire logic [3:0]                   pstrb,
   input wire logic [`OAC_DATA_W-1:0]       prdata,
   input wire logic                         pready,
   input wire logic                         pslverr,
   input oac_amp_s [`OAC_NUM_AMPS-1:0]      amp_cfg,
   input oac_switch_s                       switch_cfg
);
   logic hit;
   assign hit = (paddr[1:0] == 2'h0) && (paddr[11:2] >= 10'h0C0)
                && (paddr[11:2] <= (SMALL_VARIANT ? 10'h0C3 : 10'h0C5) || SMALL_VARIANT && paddr[11:2] == 10'h0CF);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_timing: assert property (psel && !penable |=> !pready ##1 pready) else $error("late answer");
   a_err_map: assert property (pready |-> pslverr == !hit) else $error("bad error flag");
   a_rdata_quiet: assert property (!pready || pwrite |-> prdata == 32'h0) else $error("stray read data");
   a_inv_write: assert property (psel && penable && pready && pwrite && pstrb[0] && hit
      && paddr[11:2] == 10'h0C0 && switch_cfg.force0 != 2'h1 && switch_cfg.force0 != 2'h2
      |-> ##2 amp_cfg[0].inv_input_sel == $past(pwdata[7:6], 2)) else $error("inverting select lost");
   a_power_slew: assert property (amp_cfg[0].amp_powered == (amp_cfg[0].slew_power_sel != 2'h0))
      else $error("power flag wrong");
   a_int_gate: assert property (amp_cfg[1].internal_conv_route |-> amp_cfg[1].slew_power_sel != 2'h0)
      else $error("internal route ungated");
   a_ext_gate: assert property (amp_cfg[2].external_conv_route
      |-> amp_cfg[2].amp_function_sel != OAC_FN_GENERAL) else $error("external route ungated");
   a_rdata_upper: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
   c_error: cover property (pready && pslverr);
   c_read: cover property (pready && !pwrite && prdata != 32'h0);
   c_ext: cover property (amp_cfg[2].external_conv_route);
   c_forced: cover property (amp_cfg[0].forced && amp_cfg[1].forced);
endmodule
bind oac_regs oac_regs_monitor #(.SMALL_VARIANT(SMALL_VARIANT)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .amp_cfg(amp_cfg), .switch_cfg(switch_cfg));

// File: sim/opamp_config_registers_test.sv
`timescale 1ns/1ps
`include "oac_consts.svh"
module opamp_config_registers_test
   import oac_pkg::*;
;
   logic                         pclk;
   logic                         presetn;
   logic                         psel;
   logic                         penable;
   logic                         pwrite;
   logic [`OAC_ADDR_W-1:0]       paddr;
   logic [`OAC_DATA_W-1:0]       pwdata;
   logic [3:0]                   pstrb;
   logic [`OAC_DATA_W-1:0]       prdata;
   logic                         pready;
   logic                         pslverr;
   oac_amp_s [`OAC_NUM_AMPS-1:0] amp_cfg;
   oac_amp_s [`OAC_NUM_AMPS-1:0] amp_cfg_s;
   oac_switch_s                  switch_cfg;
   oac_switch_s                  switch_cfg_s;
   logic [7:0]                   model [6];
   logic [33:0]                  notes [$];
   logic [33:0]                  nt;
   logic [7:0]                   ic;
   logic [7:0]                   fc;
   logic [7:0]                   sw;
   logic [11:0]                  bad [4] = '{12'h2FC, 12'h318, 12'h33C, 12'h301};
   int                           n_mismatch;
   int                           n_compared;

   oac_regs #(.SMALL_VARIANT(1'b0)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .amp_cfg(amp_cfg), .switch_cfg(switch_cfg));

   // Two-amplifier variant on the same bus
   oac_regs #(.SMALL_VARIANT(1'b1)) uut_small (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
      .amp_cfg(amp_cfg_s), .switch_cfg(switch_cfg_s));

   always #25 pclk = ~pclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      int         k;
      logic [9:0] x;
      logic       ok;
      x  = a[11:2] - 10'h0C0;
      ok = (a[1:0] == 2'h0) && (a[11:2] >= 10'h0C0) && (a[11:2] <= 10'h0C5);
      notes.push_back({wr, !ok, (ok && !wr) ? {24'h0, model[x]} : 32'h0});
      if (ok && wr && s[0])
         model[x] = x[0] ? (d & `OAC_FUNC_WMASK) : d;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'($urandom()), d};
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   task automatic idle(input int n);
      psel    <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask

   function automatic logic [31:0] exp_amp(input logic [7:0] i, input logic [7:0] f, input logic [1:0] fs);
      oac_amp_s e;
      e = '0;
      e.inv_input_sel       = i[7:6];
      e.noninv_input_sel    = i[5:4];
      e.slew_power_sel      = i[3:2];
      e.amp_powered         = i[3:2] != 2'h0;
      e.internal_conv_route = i[0] && i[3:2] != 2'h0;
      e.feedback_tap_sel    = f[7:5];
      e.amp_function_sel    = oac_func_e'(f[4:2]);
      e.input_range_limit   = f[0];
      if (fs == 2'h1 || fs == 2'h2)
      begin
         e.inv_input_sel    = (fs == 2'h1) ? 2'h0 : 2'h1;
         e.amp_function_sel = OAC_FN_INV_PGA;
         e.forced           = 1'b1;
      end
      e.external_conv_route = i[1] && e.amp_function_sel != OAC_FN_GENERAL;
      return {15'h0, e};
   endfunction

   // Result watcher
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0)
      begin
         nt = notes.pop_front();
         check({31'h0, pslverr}, {31'h0, nt[32]});
         if (!nt[33])
            check(prdata, nt[31:0]);
      end
   end

   initial
   begin
      pclk       = 1'b0;
      presetn    = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h000;
      pwdata     = 32'h0;
      pstrb      = 4'h0;
      n_mismatch = 0;
      n_compared = 0;
      void'($urandom(32'hF1F7));
      for (int i = 0; i < 6; i++)
         model[i] = 8'h00;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++)
         xfer(1'b0, 12'h300 + 12'(4 * i), 8'h00, 4'hF);
      idle(1);
      for (int a = 0; a < 3; a++)
         check({15'h0, amp_cfg[a]}, 32'h0);
      $display("test reset_values done");
      for (int n = 0; n < 24; n++)
      begin
         ic = 8'($urandom());
         fc = {3'($urandom()), 3'(n / 3), 2'($urandom())};
         xfer(1'b1, 12'h300 + 12'(8 * (n % 3)), ic, 4'h1);
         xfer(1'b1, 12'h304 + 12'(8 * (n % 3)), fc, 4'h1);
         xfer(1'b0, 12'h304 + 12'(8 * (n % 3)), 8'h00, 4'h0);
         idle(3);
         check({15'h0, amp_cfg[n % 3]}, exp_amp(ic, fc & 8'hFD, 2'h0));
      end
      $display("test field_decode done");
      xfer(1'b1, 12'h300, ~model[0], 4'h0);
      xfer(1'b0, 12'h300, 8'h00, 4'hF);
      $display("test strobe_off done");
      for (int b = 0; b < 4; b++)
      begin
         xfer(1'b1, bad[b], 8'hFF, 4'hF);
         xfer(1'b0, bad[b], 8'h00, 4'hF);
      end
      for (int i = 0; i < 6; i++)
         xfer(1'b0, 12'h300 + 12'(4 * i), 8'h00, 4'hF);
      idle(2);
      $display("test unmapped done");
      ic = 8'($urandom());
      fc = 8'($urandom());
      xfer(1'b1, 12'h300, ic, 4'h1);
      xfer(1'b1, 12'h304, fc, 4'h1);
      xfer(1'b1, 12'h308, ~ic, 4'h1);
      xfer(1'b1, 12'h30C, ~fc, 4'h1);
      for (int n = 0; n < 4; n++)
      begin
         sw = {2'($urandom()), 2'(n), 2'($urandom()), 2'(3 - n)};
         xfer(1'b1, 12'h33C, sw, 4'h1);
         idle(3);
         check({24'h0, switch_cfg_s}, {24'h0, sw});
         check({24'h0, switch_cfg}, 32'h0);
         check({15'h0, amp_cfg_s[0]}, exp_amp(ic, fc & 8'hFD, sw[1:0]));
         check({15'h0, amp_cfg_s[1]}, exp_amp(~ic, ~fc & 8'hFD, sw[5:4]));
         check({15'h0, amp_cfg_s[2]}, 32'h0);
      end
      $display("test switch_force done");
      report_and_stop();
   end
endmodule
